// *** pkg/qbs_pkg.sv ***
// Shared constants, types and helpers of the burst-of-four separate I/O SRAM port.
// Assumes one 20 MHz clock; each clock cycle stands for one half period of the memory clock pair.
package qbs_pkg;

  // ----------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ = 20;
  localparam logic PHASE_RST = 1'b1;
  localparam int IMP_PERIOD_US = 100;
  localparam int IMP_PERIOD_CYC = IMP_PERIOD_US * CLK_MHZ;
  localparam int ZCNT_W = 11;
  localparam logic [ZCNT_W-1:0] ZCNT_RST = 11'h000;
  localparam logic [ZCNT_W-1:0] ZCNT_LAST = ZCNT_W'(IMP_PERIOD_CYC - 1);

  // ----------------------------------------------------------------
  // Array and bus geometry
  // ----------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam int DEPTH = 256;
  localparam int BEAT_W = 18;
  localparam int BEATS = 4;
  localparam int WORD_W = BEAT_W * BEATS;
  localparam int LANE_W = 9;
  localparam int NIB_W = 4;

  // ----------------------------------------------------------------
  // Pipeline taps, counted in half periods after the command edge
  // ----------------------------------------------------------------
  localparam int WR_SR_LEN = 5;
  localparam int WR_BEAT0_TAP = 1;
  localparam int WR_COMMIT_TAP = 4;
  localparam int RD_SR_LEN = 8;
  localparam int RD_FETCH_TAP = 3;
  localparam int RD_OUT0_TAP = 4;
  localparam logic [WR_SR_LEN-1:0] WR_SR_RST = 5'h00;
  localparam logic [RD_SR_LEN-1:0] RD_SR_RST = 8'h00;
  localparam logic [BEAT_W-1:0] DOUT_RST = 18'h00000;
  localparam logic [WORD_W-1:0] WORD_RST = 72'h000000000000000000;
  localparam logic [ADDR_W-1:0] ADDR_RST = 8'h00;

  // ----------------------------------------------------------------
  // Impedance code
  // ----------------------------------------------------------------
  localparam int ZCODE_W = 6;
  localparam logic [ZCODE_W-1:0] ZCODE_RST = 6'h20;
  localparam logic [ZCODE_W-1:0] ZCODE_MAX = 6'h3F;
  localparam logic [ZCODE_W-1:0] ZCODE_MIN = 6'h00;

  // ----------------------------------------------------------------
  // Types and helpers
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    OP_DESEL = 2'b00,
    OP_READ = 2'b01,
    OP_WRITE = 2'b10
  } qbs_op_e;

  // Turns the active-low lane masks of one beat into bit enables.
  function automatic logic [BEAT_W-1:0] beat_bit_en(input logic narrow, input logic [1:0] lane_n,
                                                     input logic [1:0] half_n);
    logic [BEAT_W-1:0] en;
    en = '0;
    if (narrow)
    begin
      en[NIB_W-1:0] = {NIB_W{~half_n[0]}};
      en[2*NIB_W-1:NIB_W] = {NIB_W{~half_n[1]}};
    end
    else
    begin
      en[LANE_W-1:0] = {LANE_W{~lane_n[0]}};
      en[2*LANE_W-1:LANE_W] = {LANE_W{~lane_n[1]}};
    end
    return en;
  endfunction

endpackage

// *** rtl/qbs_mem.sv ***
// Storage array of the SRAM port: one 72-bit word per burst address, bit-level write enables.
// Assumes writer and reader never need the same word in the same cycle.
module qbs_mem
  import qbs_pkg::*;
(
  // Clock
  input wire logic clk_i,
  // Write side
  input wire logic we_i,
  input wire logic [ADDR_W-1:0] waddr_i,
  input wire logic [WORD_W-1:0] wdata_i,
  input wire logic [WORD_W-1:0] wbit_en_i,
  // Read side
  input wire logic re_i,
  input wire logic [ADDR_W-1:0] raddr_i,
  output logic [WORD_W-1:0] rdata_o
);

  logic [WORD_W-1:0] mem_r [DEPTH];

  // Bits without enable keep their old contents, so masked lanes stay undisturbed.
  always_ff @(posedge clk_i)
  begin
    if (we_i)
    begin
      for (int i = 0; i < WORD_W; i++)
      begin
        if (wbit_en_i[i])
        begin
          mem_r[waddr_i][i] <= wdata_i[i];
        end
      end
    end
  end

  // Read data come from a register and hold until the next fetch.
  always_ff @(posedge clk_i)
  begin
    if (re_i)
    begin
      rdata_o <= mem_r[raddr_i];
    end
  end

endmodule

// *** rtl/qbs_zcal.sv ***
// Periodic impedance evaluation for output drivers and input termination.
// Assumes the up and down requests come from an outside comparator and are steady at evaluation.
module qbs_zcal
  import qbs_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Comparator requests
  input wire logic drv_up_i,
  input wire logic drv_dn_i,
  input wire logic term_up_i,
  input wire logic term_dn_i,
  // Codes and evaluation strobe
  output logic [ZCODE_W-1:0] drv_code_o,
  output logic [ZCODE_W-1:0] term_code_o,
  output logic eval_o
);

  logic [ZCNT_W-1:0] zcnt_r;
  logic [ZCNT_W-1:0] zcnt_nxt;
  logic eval_nxt;

  // One binary step toward the request, clamped at both ends of the code range.
  function automatic logic [ZCODE_W-1:0] step(input logic [ZCODE_W-1:0] code, input logic up, input logic dn);
    logic [ZCODE_W-1:0] res;
    res = code;
    if (up && (code != ZCODE_MAX))
    begin
      res = code + 1'b1;
    end
    else if (dn && (code != ZCODE_MIN))
    begin
      res = code - 1'b1;
    end
    return res;
  endfunction

  // Interval counter restarts after each evaluation.
  // periodic evaluation trigger
  assign eval_nxt = (zcnt_r == ZCNT_LAST);
  assign zcnt_nxt = eval_nxt ? ZCNT_RST : zcnt_r + 1'b1;

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      zcnt_r <= ZCNT_RST;
      eval_o <= 1'b0;
    end
    else
    begin
      zcnt_r <= zcnt_nxt;
      eval_o <= eval_nxt;
    end
  end

  // Codes move only at an evaluation, so drift tracking never jumps.
  // single step update
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      drv_code_o <= ZCODE_RST;
      term_code_o <= ZCODE_RST;
    end
    else if (eval_nxt)
    begin
      drv_code_o <= step(drv_code_o, drv_up_i, drv_dn_i);
      term_code_o <= step(term_code_o, term_up_i, term_dn_i);
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  drv_one_step_a: assert property ((drv_code_o == $past(drv_code_o)) || (drv_code_o == $past(drv_code_o) + 6'h01) || (drv_code_o == $past(drv_code_o) - 6'h01)) else $error("driver code moved more than one step");
  code_hold_a: assert property (!$past(eval_nxt) |-> ($stable(drv_code_o) && $stable(term_code_o))) else $error("code changed outside evaluation");
  eval_gap_a: assert property (eval_o |=> !eval_o [*8]) else $error("evaluations too close");

endmodule

// *** rtl/qbs_port.sv ***
// Top of the burst-of-four separate I/O SRAM port: command decode, write beat capture,
// read beat output and impedance tracking.
// Assumes all pins are synchronous to clk_i; two clk_i cycles make one period of the memory
// clock pair, and k_phase_o tells which rising edge, true or complementary, comes next.

// How it works
// - At every true-clock edge the address and both active-low selects are sampled, and both high deselect the chip.
// - A low read select at a true-clock edge starts a read burst at the sampled address.
// - The read select is ignored when a read was taken at the previous true-clock edge.
// - A high read select at a true-clock edge makes the read port idle for that cycle.
// - A low write select with no read taken at a true-clock edge starts a write burst at that address.
// - The write select is ignored when a write was taken at the previous true-clock edge.
// - Write beats are captured on the next true edge, the following complementary edge, the next true edge and the next complementary edge.
// - Lane masks are sampled with each data beat, not with the command.
// - A high lane mask keeps the stored lane of that beat unchanged.
// - Each write address takes one four-beat word of 72 bits.
// - Every 9-bit lane is masked independently on every beat.
// - The narrow variant masks 4-bit lanes with the half-lane masks in the same way.
// - An internal counter starts an impedance evaluation periodically and restarts after it.
// - Each evaluation moves the driver and termination codes by at most one step.
module qbs_port
  import qbs_pkg::*;
#(
  parameter bit NARROW = 1'b0
)
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Command
  input wire logic [ADDR_W-1:0] burst_address_i,
  input wire logic read_sel_n_i,
  input wire logic write_sel_n_i,
  // Write data and masks
  input wire logic [BEAT_W-1:0] write_data_in_i,
  input wire logic [1:0] lane_mask_n_i,
  input wire logic [1:0] half_lane_mask_n_i,
  // Read data
  output logic [BEAT_W-1:0] read_data_out_o,
  output logic read_data_oe_o,
  // Clock phase
  output logic k_phase_o,
  // Impedance tracking
  input wire logic drv_up_i,
  input wire logic drv_dn_i,
  input wire logic term_up_i,
  input wire logic term_dn_i,
  output logic [ZCODE_W-1:0] drv_code_o,
  output logic [ZCODE_W-1:0] term_code_o,
  output logic zcal_eval_o
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  qbs_op_e prev_r;
  qbs_op_e prev_nxt;
  logic k_edge;
  logic rd_ok;
  logic wr_ok;
  logic rd_go;
  logic wr_go;
  logic [WR_SR_LEN-1:0] wr_sr_r;
  logic [RD_SR_LEN-1:0] rd_sr_r;
  logic [ADDR_W-1:0] wr_addr_r;
  logic [ADDR_W-1:0] commit_addr_r;
  logic [ADDR_W-1:0] rd_addr_r;
  logic [WORD_W-1:0] wbuf_r;
  logic [WORD_W-1:0] wen_r;
  logic [BEAT_W-1:0] beat_en;
  logic mem_we;
  logic mem_re;
  logic [WORD_W-1:0] mem_wdata;
  logic [WORD_W-1:0] mem_wbit_en;
  logic [WORD_W-1:0] mem_q;
  logic [BEAT_W-1:0] out_beat;
  logic out_load;
  logic oe_nxt;

  // ----------------------------------------------------------------
  // Half-period divider
  // ----------------------------------------------------------------

  // Alternates true and complementary edges; the first edge after reset is a true edge.
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      k_phase_o <= PHASE_RST;
    end
    else
    begin
      k_phase_o <= ~k_phase_o;
    end
  end

  assign k_edge = k_phase_o;

  // ----------------------------------------------------------------
  // Command decode
  // ----------------------------------------------------------------

  // Permission depends only on the command loaded at the previous true edge.
  // ignore read after read
  always_comb
  begin
    rd_ok = 1'b1;
    wr_ok = 1'b1;
    unique case (prev_r)
      OP_DESEL:
      begin
        rd_ok = 1'b1;
        wr_ok = 1'b1;
      end
      OP_READ:
      begin
        rd_ok = 1'b0;
        wr_ok = 1'b1;
      end
      OP_WRITE:
      begin
        rd_ok = 1'b1;
        wr_ok = 1'b0;
      end
      default:
      begin
        rd_ok = 1'b0;
        wr_ok = 1'b0;
      end
    endcase
  end

  // A taken read wins over the write select; an ignored read leaves the write free.
  // read start
  assign rd_go = k_edge & ~read_sel_n_i & rd_ok;
  assign wr_go = k_edge & ~write_sel_n_i & ~rd_go & wr_ok;
  assign prev_nxt = rd_go ? OP_READ : (wr_go ? OP_WRITE : OP_DESEL);

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      prev_r <= OP_DESEL;
    end
    else if (k_edge)
    begin
      prev_r <= prev_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Burst pipelines
  // ----------------------------------------------------------------

  // One bit per accepted command walks through the half-period taps.
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      wr_sr_r <= WR_SR_RST;
      rd_sr_r <= RD_SR_RST;
    end
    else
    begin
      wr_sr_r <= {wr_sr_r[WR_SR_LEN-2:0], wr_go};
      rd_sr_r <= {rd_sr_r[RD_SR_LEN-2:0], rd_go};
    end
  end

  // The write address moves on at beat 0, since a new write may reload it before commit.
  // base address per burst
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      wr_addr_r <= ADDR_RST;
      commit_addr_r <= ADDR_RST;
      rd_addr_r <= ADDR_RST;
    end
    else
    begin
      if (wr_go)
      begin
        wr_addr_r <= burst_address_i;
      end
      if (wr_sr_r[WR_BEAT0_TAP])
      begin
        commit_addr_r <= wr_addr_r;
      end
      if (rd_go)
      begin
        rd_addr_r <= burst_address_i;
      end
    end
  end

  // ----------------------------------------------------------------
  // Write beat capture
  // ----------------------------------------------------------------

  // Masks are turned into enables for the beat now on the pins.
  // masks sampled with data
  assign beat_en = beat_bit_en(NARROW, lane_mask_n_i, half_lane_mask_n_i);

  // Beats 0 to 2 are buffered; beat 3 goes straight to the array to save a cycle.
  // four beat capture
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      wbuf_r <= WORD_RST;
      wen_r <= WORD_RST;
    end
    else
    begin
      for (int k = 0; k < BEATS - 1; k++)
      begin
        if (wr_sr_r[WR_BEAT0_TAP + k])
        begin
          wbuf_r[BEAT_W*k +: BEAT_W] <= write_data_in_i;
          wen_r[BEAT_W*k +: BEAT_W] <= beat_en;
        end
      end
    end
  end

  assign mem_we = wr_sr_r[WR_COMMIT_TAP];
  assign mem_wdata = {write_data_in_i, wbuf_r[BEAT_W*(BEATS-1)-1:0]};
  assign mem_wbit_en = {beat_en, wen_r[BEAT_W*(BEATS-1)-1:0]};

  // ----------------------------------------------------------------
  // Array
  // ----------------------------------------------------------------

  // The fetch is late on purpose: a write taken two edges before the read has committed by then.
  assign mem_re = rd_sr_r[RD_FETCH_TAP];

  qbs_mem u_mem (
    .clk_i(clk_i),
    .we_i(mem_we),
    .waddr_i(commit_addr_r),
    .wdata_i(mem_wdata),
    .wbit_en_i(mem_wbit_en),
    .re_i(mem_re),
    .raddr_i(rd_addr_r),
    .rdata_o(mem_q)
  );

  // ----------------------------------------------------------------
  // Read beat output
  // ----------------------------------------------------------------

  // Beat select follows the tap that carries the read.
  // read beat timing
  assign out_load = |rd_sr_r[RD_OUT0_TAP +: BEATS];
  assign oe_nxt = out_load;
  assign out_beat = rd_sr_r[RD_OUT0_TAP] ? mem_q[0 +: BEAT_W] :
                    rd_sr_r[RD_OUT0_TAP + 1] ? mem_q[BEAT_W +: BEAT_W] :
                    rd_sr_r[RD_OUT0_TAP + 2] ? mem_q[2*BEAT_W +: BEAT_W] :
                    mem_q[3*BEAT_W +: BEAT_W];

  // Data hold the last beat while idle; only the enable marks the bus as released.
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      read_data_out_o <= DOUT_RST;
      read_data_oe_o <= 1'b0;
    end
    else
    begin
      read_data_oe_o <= oe_nxt;
      if (out_load)
      begin
        read_data_out_o <= out_beat;
      end
    end
  end

  // ----------------------------------------------------------------
  // Impedance tracking
  // ----------------------------------------------------------------

  qbs_zcal u_zcal (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .drv_up_i(drv_up_i),
    .drv_dn_i(drv_dn_i),
    .term_up_i(term_up_i),
    .term_dn_i(term_dn_i),
    .drv_code_o(drv_code_o),
    .term_code_o(term_code_o),
    .eval_o(zcal_eval_o)
  );

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  // The first edge after release still shows the reset phase, so the toggle is judged from the second edge on.
  phase_alternates_a: assert property ($past(rst_n_i) |-> k_phase_o != $past(k_phase_o)) else $error("phase did not alternate");
  // A deselect starts no burst; beats of an earlier read may still be on the bus.
  deselect_idle_a: assert property (k_edge && read_sel_n_i && write_sel_n_i |=> prev_r == OP_DESEL && !rd_sr_r[0] && !wr_sr_r[0]) else $error("deselect not taken");
  read_taken_a: assert property (k_edge && !read_sel_n_i && prev_r != OP_READ |-> rd_go && !wr_go) else $error("read not started");
  no_read_pair_a: assert property (rd_go |-> ##2 !rd_go) else $error("back to back reads");
  read_high_idle_a: assert property (k_edge && read_sel_n_i |-> ##5 !rd_sr_r[RD_OUT0_TAP]) else $error("read without select");
  write_taken_a: assert property (k_edge && !write_sel_n_i && read_sel_n_i && prev_r != OP_WRITE |-> wr_go) else $error("write not started");
  no_write_pair_a: assert property (wr_go |-> ##2 !wr_go) else $error("back to back writes");
  beat_capture_a: assert property (wr_go |-> ##2 wr_sr_r[WR_BEAT0_TAP] && k_edge ##1 !k_edge ##2 mem_we) else $error("write beat timing");
  mask_with_beat_a: assert property (wr_sr_r[WR_BEAT0_TAP] && lane_mask_n_i[0] && !NARROW |-> ##3 mem_we && mem_wbit_en[LANE_W-1:0] == 9'h000) else $error("masked lane written");
  commit_addr_a: assert property (wr_go |-> ##5 mem_we && commit_addr_r == $past(burst_address_i, 5)) else $error("write address lost");
  narrow_lanes_a: assert property (mem_we && NARROW |-> mem_wbit_en[71:62] == 10'h000) else $error("narrow variant wrote upper bits");
  read_window_a: assert property (rd_go |-> ##6 read_data_oe_o [*4]) else $error("read beats not driven");
  oe_cause_a: assert property (read_data_oe_o |-> $past(rd_go, 6) || $past(rd_go, 7) || $past(rd_go, 8) || $past(rd_go, 9)) else $error("bus driven without read");
  alternate_ok_a: assert property (rd_go ##2 !write_sel_n_i |-> wr_go) else $error("write after read refused");

  read_seen_c: cover property (rd_go ##6 read_data_oe_o [*4]);
  write_seen_c: cover property (wr_go ##5 mem_we);
  alternate_c: cover property (rd_go ##2 wr_go ##2 rd_go);
  masked_beat_c: cover property (mem_we && (mem_wbit_en != {WORD_W{1'b1}}));

endmodule

// *** sim/qbs_ctl_model.sv ***
// Behavioural memory controller that drives the SRAM port's command, beat and mask pins.
// Assumes the port's k_phase_o tells whether the coming clk_i edge is a true edge.
module qbs_ctl_model
  import qbs_pkg::*;
(
  // Clock and phase
  input wire logic clk_i,
  input wire logic k_phase_i,
  // Command pins
  output logic [ADDR_W-1:0] addr_o,
  output logic rd_n_o,
  output logic wr_n_o,
  // Write beat pins
  output logic [BEAT_W-1:0] data_o,
  output logic [1:0] mask_n_o,
  // Alignment lost
  output logic sync_bad_o
);
  timeunit 1ns;
  timeprecision 1ns;

  logic [BEAT_W+1:0] beat_q[$];

  // Pins start at a defined level, never floating.
  initial
  begin
    addr_o = 8'h00;
    rd_n_o = 1'b1;
    wr_n_o = 1'b1;
    data_o = 18'h00000;
    mask_n_o = 2'h3;
    sync_bad_o = 1'b0;
  end

  task automatic put_beat();
    logic [BEAT_W+1:0] b;
    if (beat_q.size() > 0)
      b = beat_q.pop_front();
    else
      b = ~{mask_n_o, data_o};
    {mask_n_o, data_o} <= b;
  endtask

  // One memory period: command before the true edge, then two beat slots; taken is that edge's index.
  task automatic cmd(input logic rd_n, input logic wr_n, input logic [ADDR_W-1:0] addr, input logic send,
                     input logic [WORD_W-1:0] word, input logic [7:0] mask_n, input int edge_n, output int taken);
    int k;
    k = 0;
    @(posedge clk_i);
    while (k_phase_i !== 1'b0 && k < 3)
    begin
      k++;
      @(posedge clk_i);
    end
    if (k == 3)
      sync_bad_o <= 1'b1;
    // The call comes at the last command edge: the next true edge is two edges on, plus any edges waited.
    taken = edge_n + 2 + k;
    rd_n_o <= rd_n;
    wr_n_o <= wr_n;
    addr_o <= addr;
    put_beat();
    @(posedge clk_i);
    rd_n_o <= 1'b1;
    wr_n_o <= 1'b1;
    addr_o <= ~addr;
    put_beat();
    if (send)
      for (k = 0; k < BEATS; k++)
        beat_q.push_back({mask_n[2*k+:2], word[BEAT_W*k+:BEAT_W]});
  endtask
endmodule

// *** sim/testbench.sv ***
// Self-checking bench of the SRAM port: alternating bursts, lane masks, refusals, impedance.
// Assumes the design files and the controller model are compiled first.
module testbench
  import qbs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [ADDR_W-1:0] addr;
  logic rd_n;
  logic wr_n;
  logic [BEAT_W-1:0] wdata;
  logic [BEAT_W-1:0] rdata;
  logic [1:0] mask_n;
  logic oe;
  logic kph;
  logic sync_bad;
  logic eval;
  logic [3:0] zreq = 4'h0;
  logic [ZCODE_W-1:0] dcode;
  logic [ZCODE_W-1:0] tcode;
  logic [WORD_W-1:0] shadow [DEPTH];
  logic [WORD_W-1:0] exp_q[$];
  logic [WORD_W-1:0] shadow_nb [DEPTH];
  logic [WORD_W-1:0] exp_nb_q[$];
  logic [BEAT_W-1:0] rdata_nb;
  logic oe_nb;
  int start_q[$];
  int edge_n = 0;
  int error_cnt = 0;
  int n_checks = 0;
  qbs_op_e prev_op = OP_DESEL;

  // Clock and edge count; the count times the expected read beats.
  always #25 clk_i = ~clk_i;
  always @(posedge clk_i)
    edge_n <= edge_n + 1;

  qbs_port #(.NARROW(1'b0)) qbs_port_i (.clk_i(clk_i), .rst_n_i(rst_n_i), .burst_address_i(addr),
    .read_sel_n_i(rd_n), .write_sel_n_i(wr_n), .write_data_in_i(wdata), .lane_mask_n_i(mask_n),
    .half_lane_mask_n_i(mask_n), .read_data_out_o(rdata), .read_data_oe_o(oe), .k_phase_o(kph),
    .drv_up_i(zreq[3]), .drv_dn_i(zreq[2]), .term_up_i(zreq[1]), .term_dn_i(zreq[0]),
    .drv_code_o(dcode), .term_code_o(tcode), .zcal_eval_o(eval));

  // The narrow variant sees the same pins; only its two nibble lanes per beat are judged.
  qbs_port #(.NARROW(1'b1)) qbs_port_nb_i (.clk_i(clk_i), .rst_n_i(rst_n_i), .burst_address_i(addr),
    .read_sel_n_i(rd_n), .write_sel_n_i(wr_n), .write_data_in_i(wdata), .lane_mask_n_i(mask_n),
    .half_lane_mask_n_i(mask_n), .read_data_out_o(rdata_nb), .read_data_oe_o(oe_nb), .k_phase_o(),
    .drv_up_i(zreq[3]), .drv_dn_i(zreq[2]), .term_up_i(zreq[1]), .term_dn_i(zreq[0]),
    .drv_code_o(), .term_code_o(), .zcal_eval_o());

  qbs_ctl_model qbs_ctl_model_i (.clk_i(clk_i), .k_phase_i(kph), .addr_o(addr), .rd_n_o(rd_n),
    .wr_n_o(wr_n), .data_o(wdata), .mask_n_o(mask_n), .sync_bad_o(sync_bad));

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic end_of_test();
    if (sync_bad === 1'b1)
      error_cnt++;
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic check(input logic ok, input string what);
    n_checks++;
    if (ok !== 1'b1)
    begin
      error_cnt++;
      $display("BAD at %0t: %s", $time, what);
    end
  endtask

  // Works out which command the port must take, then keeps the expected array up to date.
  task automatic issue(input logic rd, input logic wr, input logic [ADDR_W-1:0] a,
                       input logic [WORD_W-1:0] w, input logic [7:0] m);
    qbs_op_e op;
    int t;
    int k;
    op = (!rd && prev_op != OP_READ) ? OP_READ : (!wr && prev_op != OP_WRITE) ? OP_WRITE : OP_DESEL;
    qbs_ctl_model_i.cmd(rd, wr, a, op == OP_WRITE, w, m, edge_n, t);
    if (op == OP_READ)
    begin
      start_q.push_back(t + 6);
      exp_q.push_back(shadow[a]);
      exp_nb_q.push_back(shadow_nb[a]);
    end
    for (k = 0; k < WORD_W; k++)
    begin
      if (op == OP_WRITE && !m[2*(k/BEAT_W)+(k%BEAT_W)/LANE_W])
        shadow[a][k] = w[k];
      if (op == OP_WRITE && (k % BEAT_W) < 2 * NIB_W && !m[2*(k/BEAT_W)+(k%BEAT_W)/NIB_W])
        shadow_nb[a][k] = w[k];
    end
    prev_op = op;
  endtask

  // Read beats must come exactly on time; the port stays idle otherwise.
  always @(posedge clk_i)
    if (rst_n_i === 1'b1)
    begin
      if (start_q.size() > 0 && edge_n >= start_q[0])
      begin
        check(oe === 1'b1 && rdata === exp_q[0][BEAT_W*(edge_n-start_q[0])+:BEAT_W], "read beat");
        check(oe_nb === 1'b1 && rdata_nb[2*NIB_W-1:0] === exp_nb_q[0][BEAT_W*(edge_n-start_q[0])+:2*NIB_W], "narrow read beat");
        if (edge_n == start_q[0] + 3)
        begin
          void'(start_q.pop_front());
          void'(exp_q.pop_front());
          void'(exp_nb_q.pop_front());
        end
      end
      else
        check(oe === 1'b0 && oe_nb === 1'b0, "output not idle");
    end

  task automatic wait_eval(output int n);
    n = 0;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (eval !== 1'b1 && n < 2100);
    if (n >= 2100)
    begin
      error_cnt++;
      end_of_test();
    end
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_alternate();
    int i;
    for (i = 0; i < 4; i++)
    begin
      issue(1'b1, 1'b0, 8'(i*3), {18'h3C3C3, 18'h0F0F0, 18'h25A5A, 18'h1E1E1} ^ 72'(i), 8'h00);
      issue(1'b0, 1'b1, 8'(i*3), '0, 8'h00);
    end
  endtask

  // A high mask keeps the stored lane; an all-high write leaves the word alone.
  task automatic t_masks();
    issue(1'b1, 1'b0, 8'h40, {4{18'h3FFFF}}, 8'h00);
    issue(1'b1, 1'b1, 8'h40, '0, 8'h00);
    issue(1'b1, 1'b0, 8'h40, {4{18'h00000}}, 8'h46);
    issue(1'b0, 1'b1, 8'h40, '0, 8'h00);
    issue(1'b1, 1'b0, 8'h03, {4{18'h00000}}, 8'hFF);
    issue(1'b0, 1'b1, 8'h03, '0, 8'h00);
  endtask

  task automatic t_refuse();
    issue(1'b0, 1'b1, 8'h00, '0, 8'h00);
    issue(1'b0, 1'b1, 8'h06, '0, 8'h00);
    issue(1'b0, 1'b0, 8'h06, {4{18'h2D2D2}}, 8'h00);
    issue(1'b1, 1'b0, 8'h06, {4{18'h11111}}, 8'h00);
    issue(1'b1, 1'b1, 8'h06, '0, 8'h00);
    issue(1'b0, 1'b0, 8'h06, '0, 8'h00);
    repeat (6) issue(1'b1, 1'b1, 8'h00, '0, 8'h00);
  endtask

  task automatic t_zcal();
    int n;
    zreq <= 4'b1001;
    wait_eval(n);
    check(dcode === 6'h21 && tcode === 6'h1F, "code step one");
    zreq <= 4'b0110;
    @(posedge clk_i);
    check(eval === 1'b0, "evaluation strobe too long");
    wait_eval(n);
    // One edge of the period was spent on the strobe check above.
    check(n === IMP_PERIOD_CYC - 1, "evaluation period");
    check(dcode === 6'h20 && tcode === 6'h20, "code step two");
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    repeat (10) @(posedge clk_i);
    check(oe === 1'b0 && kph === 1'b1 && dcode === 6'h20 && tcode === 6'h20 && eval === 1'b0, "reset");
    rst_n_i <= 1'b1;
    t_alternate();
    t_masks();
    t_refuse();
    t_zcal();
    end_of_test();
  end
endmodule
